//--- tb/dpt_load.sv
// Far side model: fast clock pulse source and pin A with a pull-up.
// Assumes the pin direction is set to output by software.
`timescale 1ns/1ps
module dpt_load (
  input  wire mclk_i,
  input  wire reset_i,
  input  wire a_lvl_i,
  input  wire a_oe_i,
  output reg  fast_tick_o = 1'b0,
  output wire pin_a_o
);
  reg [1:0] div_reg = 2'h0; // Fast period, three system cycles
  // Released pin floats to its pull-up
  assign pin_a_o = a_oe_i ? a_lvl_i : 1'b1;
  // Free-running pulse, one cycle in three
  always @(posedge mclk_i) begin
    div_reg <= (reset_i || div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
    fast_tick_o <= !reset_i && div_reg == 2'h2;
  end
endmodule // dpt_load

//--- tb/dpt_timer_sva.sv
// Checker for dpt_timer: bus handshake and output pair relations.
// Assumes it is bound to dpt_timer and sees only its ports.
`timescale 1ns/1ps
module dpt_timer_sva (
  input wire        mclk_i,
  input wire        reset_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire        chan_a_out_o,
  input wire        chan_a_comp_o,
  input wire        chan_a_out_oe_o,
  input wire        chan_a_comp_oe_o,
  input wire        chan_b_out_o,
  input wire        chan_b_comp_o,
  input wire        chan_b_out_oe_o,
  input wire        chan_b_comp_oe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////////
  // A fresh request, then a one-cycle answer
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  a_ack_one_cycle: assert property (s_req |=> s_ans) else $error("ack not one cycle");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read upper bits set");
  a_pair_inverse_a: assert property (chan_a_comp_oe_o |-> chan_a_comp_o != chan_a_out_o)
    else $error("pair A not inverse");
  a_pair_inverse_b: assert property (chan_b_comp_oe_o |-> chan_b_comp_o != chan_b_out_o)
    else $error("pair B not inverse");
  a_comp_needs_a: assert property (chan_a_comp_oe_o |-> chan_a_out_oe_o)
    else $error("A complement without true");
  a_comp_needs_b: assert property (chan_b_comp_oe_o |-> chan_b_out_oe_o)
    else $error("B complement without true");
  // Pin connection only moves on a register write
  a_oe_after_write: assert property ($changed(chan_a_out_oe_o) || $changed(chan_a_comp_oe_o)
    |-> $past(wb_ack_o)) else $error("enable moved without write");
  a_reset_levels: assert property (disable iff (1'b0) reset_i |=> !chan_a_out_o
    && chan_a_comp_o && !chan_a_out_oe_o && !wb_ack_o) else $error("bad reset levels");
endmodule // dpt_timer_sva

bind dpt_timer dpt_timer_sva chk (.mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .chan_a_out_o(chan_a_out_o),
  .chan_a_comp_o(chan_a_comp_o), .chan_a_out_oe_o(chan_a_out_oe_o),
  .chan_a_comp_oe_o(chan_a_comp_oe_o), .chan_b_out_o(chan_b_out_o),
  .chan_b_comp_o(chan_b_comp_o), .chan_b_out_oe_o(chan_b_out_oe_o),
  .chan_b_comp_oe_o(chan_b_comp_oe_o));

//--- tb/dual_pwm_timer_8bit_bench.sv
// Bench: register tasks, duty and period counts, flags and enables.
// Assumes dpt_load gives the fast pulse; top register set to 3.
`timescale 1ns/1ps
module dual_pwm_timer_8bit_bench;
  reg         mclk_i = 1'b0;
  reg         reset_i = 1'b1;
  reg         cyc = 1'b0, stb = 1'b0, we = 1'b0, use_b = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] dat = 32'h0, got;
  wire [31:0] rdat;
  wire        ack, a_out, a_oe, a_coe, b_out, b_coe, ovf_irq, tick, pin_a;
  wire        b_oe, a_irq, b_irq;
  integer     bad_count = 0;
  integer     checks_done = 0;
  dpt_timer uut (.mclk_i(mclk_i), .reset_i(reset_i), .fast_tick_i(tick), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .chan_a_out_o(a_out), .chan_a_out_oe_o(a_oe),
    .chan_a_comp_o(), .chan_a_comp_oe_o(a_coe), .chan_b_out_o(b_out), .chan_b_out_oe_o(b_oe),
    .chan_b_comp_o(), .chan_b_comp_oe_o(b_coe), .ovf_irq_o(ovf_irq), .cmp_a_irq_o(a_irq),
    .cmp_b_irq_o(b_irq));
  dpt_load load (.mclk_i(mclk_i), .reset_i(reset_i), .a_lvl_i(a_out), .a_oe_i(a_oe),
    .fast_tick_o(tick), .pin_a_o(pin_a));
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task check(input [31:0] g, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // One classic cycle; request held until ack is sampled high
  task bus(input w, input [7:0] a, input [7:0] d);
    integer n;
    begin
      @(posedge mclk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      n = 0;
      @(posedge mclk_i);
      while (ack !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge mclk_i);
      end
      if (n == 20) bad_count = bad_count + 1;
      got = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      bus(1'b0, a, 8'h00);
      check(got, {24'h0, e});
    end
  endtask
  // Settle, then count high cycles over 48, a whole number of periods
  task run(input [7:0] ctl, input [7:0] cmp, input [7:0] exp);
    integer i, hi;
    begin
      bus(1'b1, 8'h44, cmp);
      bus(1'b1, 8'h30, ctl);
      repeat (24) @(posedge mclk_i);
      hi = 0;
      for (i = 0; i < 48; i = i + 1) begin
        @(posedge mclk_i);
        if ((use_b ? b_out : a_out) === 1'b1) hi = hi + 1;
      end
      check(hi, {24'h0, exp});
      check(a_coe, ctl[6] && ctl[5:4] == 2'h1);
      $display("test done ctrl %h cmp %h", ctl, cmp);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(8'h30, 8'h00);
    rd(8'h4c, 8'hff);
    rd(8'h44, 8'h00);
    rd(8'h00, 8'h00);
    bus(1'b1, 8'h4c, 8'h03);
    run(8'h51, 8'h01, 8'd12);
    run(8'h61, 8'h01, 8'd12);
    run(8'h71, 8'h01, 8'd36);
    run(8'h52, 8'h02, 8'd24);
    run(8'h53, 8'h01, 8'd12);
    run(8'h51, 8'h00, 8'd0);
    run(8'h51, 8'h03, 8'd48);
    run(8'h71, 8'h00, 8'd48);
    run(8'h71, 8'h03, 8'd0);
    bus(1'b1, 8'h58, 8'h01);
    run(8'h51, 8'h01, 8'd12);
    bus(1'b1, 8'h58, 8'h00);
    run(8'h91, 8'h01, 8'd24);
    run(8'ha1, 8'h01, 8'd0);
    run(8'hb1, 8'h01, 8'd48);
    use_b = 1'b1;
    bus(1'b1, 8'h48, 8'h01);
    bus(1'b1, 8'h2c, 8'h50);
    run(8'h51, 8'h01, 8'd12);
    check(b_coe, 1'b1);
    check(b_oe, 1'b1);
    bus(1'b1, 8'h44, 8'h02);
    rd(8'h44, 8'h02);
    rd(8'h50, 8'h07);
    bus(1'b1, 8'h54, 8'h09);
    @(posedge mclk_i);
    check(ovf_irq, 1'b1);
    bus(1'b1, 8'h54, 8'h0e);
    @(posedge mclk_i);
    check(ovf_irq, 1'b0);
    check(a_irq, 1'b1);
    check(b_irq, 1'b1);
    // Mode 00 with the counter stopped, so no new events refill the flags
    bus(1'b1, 8'h30, 8'h40);
    repeat (8) @(posedge mclk_i);
    check(pin_a, 1'b1);
    check(a_oe, 1'b0);
    bus(1'b1, 8'h50, 8'h07);
    rd(8'h50, 8'h00);
    bus(1'b0, 8'h40, 8'h00);
    rd(8'h40, got[7:0]);
    stop_test;
  end
  initial begin
    #40000;
    bad_count = bad_count + 1;
    stop_test;
  end
endmodule // dual_pwm_timer_8bit_bench

//--- verilog/dpt_channel.v
// One compare channel: true and complementary outputs with enables.
// Assumes count_i is stable after upd_i and compare/top values are the active copies.
`timescale 1ns/1ps
`include "dpt_map.vh"

module dpt_channel (
  input  wire       mclk_i,       // System clock
  input  wire       reset_i,      // Synchronous reset, active high
  input  wire       pwm_en_i,     // Channel runs in PWM mode
  input  wire [1:0] mode_i,       // chan_out_mode_hi, chan_out_mode_lo
  input  wire       upd_i,        // Counter took a tick-driven value last edge
  input  wire [7:0] count_i,      // count_value
  input  wire [7:0] cmp_i,        // Active compare value
  input  wire [7:0] top_i,        // top_value
  input  wire       force_i,      // Forced compare action, normal mode only
  output reg        true_o,       // True output level
  output reg        comp_o,       // Complementary output level
  output wire       true_oe_o,    // True output connected to its pin
  output wire       comp_oe_o,    // Complementary output connected to its pin
  output wire       match_o       // Compare match event
);

  ////////////////////////////////////////////////////////////////////////////
  reg  out_next;                  // Shared compare result of both outputs
  wire at_zero;                   // Counter reached zero
  wire hit;                       // Counter reached compare value

  assign at_zero = upd_i && (count_i == 8'h00);
  assign hit     = upd_i && (count_i == cmp_i);
  assign match_o = hit;

  // Output state; match handled after zero so compare zero gives a static level
  always @* begin
    out_next = true_o;
    if (pwm_en_i) begin
      if (at_zero) begin
        out_next = (mode_i != `DPT_MODE_SET);
      end
      // Compare equal to top never acts, which holds the level static
      if (hit && (cmp_i != top_i)) begin
        out_next = (mode_i == `DPT_MODE_SET);
      end
    end else if (hit || force_i) begin
      case (mode_i)
        `DPT_MODE_PAIR:  out_next = ~true_o;
        `DPT_MODE_CLEAR: out_next = 1'b0;
        `DPT_MODE_SET:   out_next = 1'b1;
        default:         out_next = true_o;
      endcase
    end
  end

  // Both outputs load from one result, so the pair never overlaps or gaps
  always @(posedge mclk_i) begin
    if (reset_i) begin
      true_o <= 1'b0;
      comp_o <= 1'b1;
    end else begin
      true_o <= out_next;
      comp_o <= ~out_next;
    end
  end

  assign true_oe_o = (mode_i != `DPT_MODE_OFF);
  assign comp_oe_o = pwm_en_i && (mode_i == `DPT_MODE_PAIR);

endmodule // dpt_channel

//--- verilog/dpt_map.vh
// Register map, field positions, reset values and timing counts of the dual PWM timer.
// Assumes a 32-bit classic Wishbone slave with byte addresses; 8-bit registers sit low.
`ifndef DPT_MAP_VH
`define DPT_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define DPT_ADDR_CTRL      8'h30  // timer_one_control
`define DPT_ADDR_GCTRL     8'h2c  // Channel B control, force strobes, prescaler reset
`define DPT_ADDR_COUNT     8'h40  // count_value
`define DPT_ADDR_CMP_A     8'h44  // chan_a_compare
`define DPT_ADDR_CMP_B     8'h48  // chan_b_compare
`define DPT_ADDR_TOP       8'h4c  // top_value
`define DPT_ADDR_FLAGS     8'h50  // Event flags, write one to clear
`define DPT_ADDR_IRQ_EN    8'h54  // Interrupt enables
`define DPT_ADDR_CLK_SEL   8'h58  // fast_clock_select

////////////////////////////////////////////////////////////////////////////////
// timer_one_control fields
`define DPT_CTRL_CLEAR_ON_TOP  7
`define DPT_CTRL_PWM_A         6
`define DPT_CTRL_MODE_A_HI     5
`define DPT_CTRL_MODE_A_LO     4
`define DPT_CTRL_CS_HI         3
`define DPT_CTRL_CS_LO         0
// Global control fields
`define DPT_GCTRL_PWM_B        6
`define DPT_GCTRL_MODE_B_HI    5
`define DPT_GCTRL_MODE_B_LO    4
`define DPT_GCTRL_FORCE_B      3
`define DPT_GCTRL_FORCE_A      2
`define DPT_GCTRL_PSC_RESET    1
// Flag and enable fields (same positions in both registers)
`define DPT_FLAG_OVF           0
`define DPT_FLAG_CMP_A         1
`define DPT_FLAG_CMP_B         2
`define DPT_IRQ_EN_GLOBAL      3

////////////////////////////////////////////////////////////////////////////////
// Reset values and constants
`define DPT_RST_CTRL       8'h00
`define DPT_RST_GCTRL      8'h00
`define DPT_RST_TOP        8'hff
`define DPT_RST_CMP        8'h00
`define DPT_CS_STOP        4'h0
`define DPT_MODE_OFF       2'h0
`define DPT_MODE_PAIR      2'h1
`define DPT_MODE_CLEAR     2'h2
`define DPT_MODE_SET       2'h3
// Cycles between a counter event and its visible flag
`define DPT_FLAG_SYNC_CYCLES 1

`endif

//--- verilog/dpt_prescaler.v
// Prescaler of the dual PWM timer: turns the selected time base into a counter tick.
// Assumes fast_tick_i is a one-cycle pulse synchronous to mclk_i.
`timescale 1ns/1ps
`include "dpt_map.vh"

module dpt_prescaler #(
  parameter DIV_W = 15            // Divider width, enough for divide by 16384
) (
  input  wire       mclk_i,       // System clock
  input  wire       reset_i,      // Synchronous reset, active high
  input  wire       fast_sel_i,   // Use the fast peripheral clock tick as base
  input  wire       fast_tick_i,  // One pulse per fast peripheral clock period
  input  wire       psc_clr_i,    // Restart the divider
  input  wire [3:0] cs_i,         // clock_select_field
  output wire       tick_o        // Counter advance enable
);

  ////////////////////////////////////////////////////////////////////////////
  reg  [DIV_W-1:0] div_reg;       // Free divider of base ticks
  reg  [DIV_W-1:0] div_next;
  wire             base_tick;     // One base period elapsed
  reg  [DIV_W-1:0] mask;          // Low divider bits that must all be one

  assign base_tick = fast_sel_i ? fast_tick_i : 1'b1;

  // Divider advances once per base tick
  always @* begin
    div_next = div_reg;
    if (psc_clr_i) begin
      div_next = {DIV_W{1'b0}};
    end else if (base_tick) begin
      div_next = div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      div_reg <= {DIV_W{1'b0}};
    end else begin
      div_reg <= div_next;
    end
  end

  // Select code n divides by 2^(n-1); code zero stops the counter
  always @* begin
    if (cs_i == `DPT_CS_STOP) begin
      mask = {DIV_W{1'b0}};
    end else begin
      mask = ({{(DIV_W-1){1'b0}}, 1'b1} << (cs_i - 4'h1)) - {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  assign tick_o = (cs_i != `DPT_CS_STOP) && base_tick &&
                  ((div_reg & mask) == mask);

endmodule // dpt_prescaler

//--- verilog/dpt_timer.v
// Top of the dual 8-bit PWM timer: Wishbone register file, counter, flags, two channels.
// Assumes a classic Wishbone master on mclk_i and a fast peripheral tick synchronous to it.
// Port direction for the output pins is kept outside; the enables here only say who drives.
`timescale 1ns/1ps
`include "dpt_map.vh"

// Overview of operation
// - PWM counter runs zero to top, repeats
// - Two PWM channels, true and complement pins
// - Pair non-overlap is fixed at zero
// - Counter wrap to zero sets overflow flag after delay
// - PWM mode 00 disconnects both outputs
// - Mode 01: true clears on match, complement opposite
// - Mode 10: true clears on match, sets zero
// - Mode 11: true sets on match, clears zero
// - PWM compare writes buffered until top reached
// - Compare reads return latest written value
// - Compare at zero or top gives static levels
// - Interrupt needs flag, enable and global enable
// - Period equals top plus one ticks; 256 ticks without PWM or clear-on-top
// - Clock select codes divide by powers of two
// - Clear-on-top zeroes counter after top match
// - Channel A PWM enable clears after top
// - Normal mode: toggle, clear or set on match
// - Fast clock select picks peripheral clock base
// - Clock select zero stops the counter
// - Channel B PWM enable clears after top
module dpt_timer (
  input  wire        mclk_i,          // System clock, 250 MHz
  input  wire        reset_i,         // Synchronous reset, active high
  input  wire        fast_tick_i,     // fast_peripheral_clock period pulse
  input  wire        wb_cyc_i,        // Wishbone cycle
  input  wire        wb_stb_i,        // Wishbone strobe
  input  wire        wb_we_i,         // Wishbone write enable
  input  wire [7:0]  wb_adr_i,        // Wishbone byte address
  input  wire [3:0]  wb_sel_i,        // Wishbone byte selects
  input  wire [31:0] wb_dat_i,        // Wishbone write data
  output reg  [31:0] wb_dat_o,        // Wishbone read data
  output reg         wb_ack_o,        // Wishbone acknowledge
  output wire        chan_a_out_o,    // pin_chan_a_true level
  output wire        chan_a_out_oe_o, // pin_chan_a_true driven
  output wire        chan_a_comp_o,   // pin_chan_a_comp level
  output wire        chan_a_comp_oe_o,// pin_chan_a_comp driven
  output wire        chan_b_out_o,    // pin_chan_b_true level
  output wire        chan_b_out_oe_o, // pin_chan_b_true driven
  output wire        chan_b_comp_o,   // pin_chan_b_comp level
  output wire        chan_b_comp_oe_o,// pin_chan_b_comp driven
  output wire        ovf_irq_o,       // Overflow interrupt request
  output wire        cmp_a_irq_o,     // Channel A compare interrupt request
  output wire        cmp_b_irq_o      // Channel B compare interrupt request
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [7:0] ctrl_reg;          // timer_one_control
  reg  [6:4] gctrl_reg;         // Channel B enable and mode
  reg  [7:0] count_reg;         // count_value
  reg  [7:0] count_next;
  reg  [7:0] top_reg;           // top_value
  reg  [7:0] cmp_a_reg;         // Active compare A
  reg  [7:0] cmp_b_reg;         // Active compare B
  reg  [7:0] cmp_a_buf_reg;     // Written compare A, what software reads back
  reg  [7:0] cmp_b_buf_reg;     // Written compare B
  reg  [2:0] flags_reg;         // Overflow, compare A, compare B
  reg  [2:0] flags_next;
  reg  [3:0] irq_en_reg;        // Per-flag enables and global enable
  reg        fast_sel_reg;      // fast_clock_select
  reg        upd_reg;           // Counter took a tick-driven value last edge
  reg        ovf_evt_reg;       // Overflow event, one synchronisation stage
  reg  [1:0] cmp_evt_reg;       // Compare events, one synchronisation stage
  reg        force_a_reg;       // Forced action strobe for channel A
  reg        force_b_reg;       // Forced action strobe for channel B
  reg        psc_clr_reg;       // Prescaler restart strobe

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls and events
  wire       tick;              // Prescaled counter tick
  wire       pwm_a;             // chan_a_pwm_enable
  wire       pwm_b;             // chan_b_pwm_enable
  wire       pwm_any;           // Either channel in PWM mode
  wire       top_hit;           // Tick while counter sits at top
  wire       wrap;              // Counter returns to zero on this tick
  wire       match_a;           // Channel A compare match
  wire       match_b;           // Channel B compare match
  wire       wb_req;            // Request pending, not yet answered
  wire       wb_wr;             // Write takes effect this edge
  wire       wr_lane;           // Low byte lane selected

  assign pwm_a   = ctrl_reg[`DPT_CTRL_PWM_A];
  assign pwm_b   = gctrl_reg[`DPT_GCTRL_PWM_B];
  assign pwm_any = pwm_a | pwm_b;
  assign top_hit = tick && (count_reg == top_reg);
  // Leaving top restarts at zero when any clear source is on; else full 8-bit wrap
  assign wrap    = tick && ((top_hit && (ctrl_reg[`DPT_CTRL_CLEAR_ON_TOP] || pwm_any)) ||
                            (count_reg == 8'hff));
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wr_lane = wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  dpt_prescaler #(
    .DIV_W (15)
  ) u_psc (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .fast_sel_i  (fast_sel_reg),
    .fast_tick_i (fast_tick_i),
    .psc_clr_i   (psc_clr_reg),
    .cs_i        (ctrl_reg[`DPT_CTRL_CS_HI:`DPT_CTRL_CS_LO]),
    .tick_o      (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter: a software write wins and never produces a compare match
  always @* begin
    count_next = count_reg;
    if (wb_wr && wr_lane && (wb_adr_i == `DPT_ADDR_COUNT)) begin
      count_next = wb_dat_i[7:0];
    end else if (wrap) begin
      count_next = 8'h00;
    end else if (tick) begin
      count_next = count_reg + 8'h01;
    end
  end

  // Counter state and the marker that compares look at the fresh value
  always @(posedge mclk_i) begin
    if (reset_i) begin
      count_reg <= 8'h00;
      upd_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      upd_reg   <= tick && !(wb_wr && wr_lane && (wb_adr_i == `DPT_ADDR_COUNT));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare buffers: in PWM mode the active copy only moves at top, so a
  // write mid-period cannot cut a pulse short
  always @(posedge mclk_i) begin
    if (reset_i) begin
      cmp_a_reg     <= `DPT_RST_CMP;
      cmp_b_reg     <= `DPT_RST_CMP;
      cmp_a_buf_reg <= `DPT_RST_CMP;
      cmp_b_buf_reg <= `DPT_RST_CMP;
    end else begin
      if (wb_wr && wr_lane && (wb_adr_i == `DPT_ADDR_CMP_A)) begin
        cmp_a_buf_reg <= wb_dat_i[7:0];
      end
      if (wb_wr && wr_lane && (wb_adr_i == `DPT_ADDR_CMP_B)) begin
        cmp_b_buf_reg <= wb_dat_i[7:0];
      end
      // Channel A active copy
      if (!pwm_a) begin
        cmp_a_reg <= cmp_a_buf_reg;
      end else if (top_hit) begin
        cmp_a_reg <= cmp_a_buf_reg;
      end
      // Channel B active copy
      if (!pwm_b) begin
        cmp_b_reg <= cmp_b_buf_reg;
      end else if (top_hit) begin
        cmp_b_reg <= cmp_b_buf_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  dpt_channel u_chan_a (
    .mclk_i    (mclk_i),
    .reset_i   (reset_i),
    .pwm_en_i  (pwm_a),
    .mode_i    (ctrl_reg[`DPT_CTRL_MODE_A_HI:`DPT_CTRL_MODE_A_LO]),
    .upd_i     (upd_reg),
    .count_i   (count_reg),
    .cmp_i     (cmp_a_reg),
    .top_i     (top_reg),
    .force_i   (force_a_reg),
    .true_o    (chan_a_out_o),
    .comp_o    (chan_a_comp_o),
    .true_oe_o (chan_a_out_oe_o),
    .comp_oe_o (chan_a_comp_oe_o),
    .match_o   (match_a)
  );

  dpt_channel u_chan_b (
    .mclk_i    (mclk_i),
    .reset_i   (reset_i),
    .pwm_en_i  (pwm_b),
    .mode_i    (gctrl_reg[`DPT_GCTRL_MODE_B_HI:`DPT_GCTRL_MODE_B_LO]),
    .upd_i     (upd_reg),
    .count_i   (count_reg),
    .cmp_i     (cmp_b_reg),
    .top_i     (top_reg),
    .force_i   (force_b_reg),
    .true_o    (chan_b_out_o),
    .comp_o    (chan_b_comp_o),
    .true_oe_o (chan_b_out_oe_o),
    .comp_oe_o (chan_b_comp_oe_o),
    .match_o   (match_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flags: events pass one stage before they show, mirroring the delayed
  // visibility software must expect; a set in the clearing cycle wins
  always @* begin
    flags_next = flags_reg;
    if (wb_wr && wr_lane && (wb_adr_i == `DPT_ADDR_FLAGS)) begin
      flags_next = flags_reg & ~wb_dat_i[2:0];
    end
    if (ovf_evt_reg) begin
      flags_next[`DPT_FLAG_OVF] = 1'b1;
    end
    if (cmp_evt_reg[0]) begin
      flags_next[`DPT_FLAG_CMP_A] = 1'b1;
    end
    if (cmp_evt_reg[1]) begin
      flags_next[`DPT_FLAG_CMP_B] = 1'b1;
    end
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      flags_reg   <= 3'h0;
      ovf_evt_reg <= 1'b0;
      cmp_evt_reg <= 2'h0;
    end else begin
      flags_reg   <= flags_next;
      ovf_evt_reg <= wrap;
      cmp_evt_reg <= {match_b, match_a};
    end
  end

  // Requests need flag, its own enable and the global enable
  assign ovf_irq_o   = flags_reg[`DPT_FLAG_OVF] && irq_en_reg[`DPT_FLAG_OVF] &&
                       irq_en_reg[`DPT_IRQ_EN_GLOBAL];
  assign cmp_a_irq_o = flags_reg[`DPT_FLAG_CMP_A] && irq_en_reg[`DPT_FLAG_CMP_A] &&
                       irq_en_reg[`DPT_IRQ_EN_GLOBAL];
  assign cmp_b_irq_o = flags_reg[`DPT_FLAG_CMP_B] && irq_en_reg[`DPT_FLAG_CMP_B] &&
                       irq_en_reg[`DPT_IRQ_EN_GLOBAL];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and one-cycle strobes
  always @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_reg     <= `DPT_RST_CTRL;
      gctrl_reg    <= 3'h0;
      top_reg      <= `DPT_RST_TOP;
      irq_en_reg   <= 4'h0;
      fast_sel_reg <= 1'b0;
      force_a_reg  <= 1'b0;
      force_b_reg  <= 1'b0;
      psc_clr_reg  <= 1'b0;
    end else begin
      force_a_reg <= 1'b0;
      force_b_reg <= 1'b0;
      psc_clr_reg <= 1'b0;
      if (wb_wr && wr_lane) begin
        case (wb_adr_i)
          `DPT_ADDR_CTRL: begin
            ctrl_reg    <= wb_dat_i[7:0];
          end
          `DPT_ADDR_GCTRL: begin
            gctrl_reg   <= wb_dat_i[6:4];
            // Forces only act outside PWM; new mode bits apply in the same write
            force_a_reg <= wb_dat_i[`DPT_GCTRL_FORCE_A] & ~pwm_a;
            force_b_reg <= wb_dat_i[`DPT_GCTRL_FORCE_B] & ~wb_dat_i[`DPT_GCTRL_PWM_B];
            psc_clr_reg <= wb_dat_i[`DPT_GCTRL_PSC_RESET];
          end
          `DPT_ADDR_TOP: begin
            top_reg     <= wb_dat_i[7:0];
          end
          `DPT_ADDR_IRQ_EN: begin
            irq_en_reg  <= wb_dat_i[3:0];
          end
          `DPT_ADDR_CLK_SEL: begin
            fast_sel_reg <= wb_dat_i[0];
          end
          default: begin
            fast_sel_reg <= fast_sel_reg;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone answer: ack one cycle after the request, data latched with it;
  // unmapped addresses are acknowledged and read as zero
  always @(posedge mclk_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        case (wb_adr_i)
          `DPT_ADDR_CTRL:    wb_dat_o <= {24'h000000, ctrl_reg};
          `DPT_ADDR_GCTRL:   wb_dat_o <= {25'h0, gctrl_reg, 4'h0};
          `DPT_ADDR_COUNT:   wb_dat_o <= {24'h000000, count_reg};
          `DPT_ADDR_CMP_A:   wb_dat_o <= {24'h000000, cmp_a_buf_reg};
          `DPT_ADDR_CMP_B:   wb_dat_o <= {24'h000000, cmp_b_buf_reg};
          `DPT_ADDR_TOP:     wb_dat_o <= {24'h000000, top_reg};
          `DPT_ADDR_FLAGS:   wb_dat_o <= {29'h0, flags_reg};
          `DPT_ADDR_IRQ_EN:  wb_dat_o <= {28'h0000000, irq_en_reg};
          `DPT_ADDR_CLK_SEL: wb_dat_o <= {31'h0, fast_sel_reg};
          default:           wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // dpt_timer
